//--- sfc_array.sv
// Purpose: Byte-wide flash array with a registered read port
// Assumes: Load port is used by the bench to fill contents
// Notes:   Read data lags the address by one i_clock cycle
`timescale 1ns/10ps
module sfc_array
	import sfc_pkg::*;
(
	// Clock
	input  wire logic                i_clock,
	// Read port
	input  wire logic [ARRAY_AW-1:0] i_rd_addr,
	output logic [7:0]               o_rd_data,
	// Load port
	input  wire logic                i_ld_en,
	input  wire logic [ARRAY_AW-1:0] i_ld_addr,
	input  wire logic [7:0]          i_ld_data
);

	logic [7:0] mem [0:(1<<ARRAY_AW)-1];

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// No reset: contents are data, not control state
	always_ff @(posedge i_clock) begin
		if (i_ld_en) begin
			mem[i_ld_addr] <= i_ld_data;
		end
		o_rd_data <= mem[i_rd_addr];
	end

endmodule

//--- sfc_core.sv
// Purpose: Serial flash command interpreter for latch, status and read opcodes
// Assumes: Link pins come from outside and pass two flip-flops before use
// Notes:   Single-line, dual-output and quad-command-mode framing supported
//
// Operation
// - Write-enable opcode sets the latch
// - Volatile enable allows status write, latch unchanged
// - Write-disable opcode clears the latch
// - Latch clears at reset and when a timed write cycle starts
// - Status read streams register MSB first, repeating
// - Status write touches only writable bits
// - Status write executes only after 8/16 bits
// - Eight-bit status write clears register-2 bits
// - Valid write without volatile enable runs timed busy cycle, clears latch
// - Register-2 write takes one byte, needs latch or volatile enable
// - Read streams addressed byte on falling edges
// - Read address increments, streaming whole array
// - Array reads while busy are ignored entirely
// - Fast read: address, dummy clocks, then data
// - Quad mode dummy 4 or 6 by parameter
// - Dual read: address, eight dummies, two lines
// - Dual data: odd bit IO1, even IO0
// - Quad data: nibbles, high nibble first
`timescale 1ns/10ps
module sfc_core
	import sfc_pkg::*;
#(
	parameter int TW_CYC = TW_CYCLES
)
(
	// Clock and reset
	input  wire logic                i_clock,
	input  wire logic                i_srst,
	// Link pins
	input  wire logic                i_cs_n,
	input  wire logic                i_sclk,
	input  wire logic [3:0]          i_io,
	output logic [3:0]               o_io,
	output logic [3:0]               o_io_oe,
	// Configuration
	input  wire logic                i_quad_cmd_mode,
	// Array load port
	input  wire logic                i_ld_en,
	input  wire logic [ARRAY_AW-1:0] i_ld_addr,
	input  wire logic [7:0]          i_ld_data,
	// Status view
	output logic [7:0]               o_status1,
	output logic [7:0]               o_status2,
	output logic                     o_busy,
	output logic                     o_write_enable_latch,
	output logic                     o_volatile_enable,
	output logic                     o_dummy6
);

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	sfc_pins_t  raw_pins;
	sfc_pins_t  pin;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_rise;
	logic [7:0] mem_data;
	sfc_core_t  q;
	sfc_core_t  d;

	assign raw_pins = '{cs_n: i_cs_n, sclk: i_sclk, io: i_io};

	sfc_pin_sync u_sync (
		.i_clock     (i_clock),
		.i_srst      (i_srst),
		.i_pins      (raw_pins),
		.o_pins      (pin),
		.o_sclk_rise (sclk_rise),
		.o_sclk_fall (sclk_fall),
		.o_cs_rise   (cs_rise)
	);

	sfc_array u_array (
		.i_clock   (i_clock),
		.i_rd_addr (q.addr[ARRAY_AW-1:0]),
		.o_rd_data (mem_data),
		.i_ld_en   (i_ld_en),
		.i_ld_addr (i_ld_addr),
		.i_ld_data (i_ld_data)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Merge only the writable bits of a status byte
	function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
	                                          input logic [7:0] new_v,
	                                          input logic [7:0] mask);
		merge_bits = (old_v & ~mask) | (new_v & mask);
	endfunction

	logic [23:0] sh_next;
	logic [5:0]  in_w;
	logic [5:0]  cnt_next;
	logic [7:0]  op;
	logic [7:0]  src_byte;
	logic [7:0]  cur_byte;
	logic [3:0]  cur_bits;
	logic [7:0]  sr1_full;
	logic [7:0]  sr1_new;
	logic        wr_ok;
	logic        commit;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d        = q;
		in_w     = i_quad_cmd_mode ? 6'd4 : 6'd1;
		sh_next  = i_quad_cmd_mode ? {q.sh[19:0], pin.io} : {q.sh[22:0], pin.io[0]};
		cnt_next = (q.cnt > CNT_SAT) ? q.cnt : q.cnt + in_w;
		op       = sh_next[7:0];
		sr1_full = {q.sr1_hi, q.write_enable_latch, q.busy};
		sr1_new  = (q.cnt == WR_TWO_BYTES) ? q.sh[15:8] : q.sh[7:0];
		wr_ok    = ~q.busy & (q.vol_en | q.write_enable_latch);
		commit   = 1'b0;
		cur_byte = 8'h00;
		cur_bits = 4'h0;
		src_byte = mem_data;
		unique case (q.src)
			SRC_SR1:   src_byte = sr1_full;
			SRC_SR2:   src_byte = q.sr2;
			SRC_ARRAY: src_byte = mem_data;
			default:   src_byte = mem_data;
		endcase

		// Self-timed write cycle; busy drops when the count runs out
		if (q.busy) begin
			if (q.tw_cnt <= 32'd1) begin
				d.busy   = 1'b0;
				d.tw_cnt = 32'h00000000;
			end else begin
				d.tw_cnt = q.tw_cnt - 32'd1;
			end
		end

		if (cs_rise) begin
			// Frame end: commands act only when framed to the exact bit
			unique case (q.cmd)
				OP_WREN: begin
					if (q.cnt == OPCODE_BITS && !q.busy) begin
						d.write_enable_latch = 1'b1;
					end
				end
				OP_WRDI: begin
					if (q.cnt == OPCODE_BITS && !q.busy) begin
						d.write_enable_latch = 1'b0;
					end
				end
				OP_VWREN: begin
					if (q.cnt == OPCODE_BITS) begin
						d.vol_en = 1'b1;
					end
				end
				OP_WRSR: begin
					if (q.phase == PH_IN && wr_ok &&
					    (q.cnt == WR_ONE_BYTE || q.cnt == WR_TWO_BYTES)) begin
						d.sr1_hi = 6'(merge_bits(sr1_full, sr1_new, SR1_WMASK) >> 2);
						if (q.cnt == WR_TWO_BYTES) begin
							d.sr2 = merge_bits(q.sr2, q.sh[7:0], SR2_WMASK);
						end else begin
							d.sr2 = q.sr2 & ~SR2_WMASK;
						end
						commit = 1'b1;
					end
				end
				OP_WRSR2: begin
					if (q.phase == PH_IN && wr_ok && q.cnt == WR_ONE_BYTE) begin
						d.sr2  = merge_bits(q.sr2, q.sh[7:0], SR2_WMASK);
						commit = 1'b1;
					end
				end
				OP_SETPARAM: begin
					if (q.phase == PH_IN && q.cnt == WR_ONE_BYTE) begin
						d.dummy6 = q.sh[PARAM_DUMMY_BIT];
					end
				end
				default: begin
				end
			endcase
			// Volatile writes finish at once; others start the timed cycle
			if (commit) begin
				if (q.vol_en) begin
					d.vol_en = 1'b0;
				end else begin
					d.busy   = 1'b1;
					d.write_enable_latch    = 1'b0;
					d.tw_cnt = 32'(TW_CYC);
				end
			end
		end

		if (pin.cs_n) begin
			// Deselected: release the lines and rearm for an opcode
			d.phase = PH_OPCODE;
			d.cmd   = OP_NONE;
			d.cnt   = 6'h00;
			d.obits = 4'h0;
			d.io_oe = 4'h0;
		end else if (sclk_rise) begin
			unique case (q.phase)
				PH_OPCODE: begin
					d.sh  = sh_next;
					d.cnt = cnt_next;
					if (cnt_next == OPCODE_BITS) begin
						d.cmd   = op;
						d.phase = PH_SKIP;
						d.lanes = i_quad_cmd_mode ? 4'd4 : 4'd1;
						d.dmy   = 4'h0;
						unique case (op)
							OP_RDSR1: begin
								d.phase = PH_OUT;
								d.src   = SRC_SR1;
							end
							OP_RDSR2: begin
								d.phase = PH_OUT;
								d.src   = SRC_SR2;
							end
							OP_WRSR, OP_WRSR2, OP_SETPARAM: begin
								d.phase = PH_IN;
								d.cnt   = 6'h00;
							end
							OP_READ: begin
								d.phase = q.busy ? PH_SKIP : PH_ADDR;
								d.lanes = 4'd1;
								d.cnt   = 6'h00;
							end
							OP_FREAD: begin
								d.phase = q.busy ? PH_SKIP : PH_ADDR;
								d.cnt   = 6'h00;
								if (i_quad_cmd_mode) begin
									d.dmy = q.dummy6 ? QPI_DUMMY_LONG : QPI_DUMMY_SHORT;
								end else begin
									d.dmy = SPI_FREAD_DUMMY;
								end
							end
							OP_DREAD: begin
								// Dual output exists only with single-line commands
								d.phase = (q.busy || i_quad_cmd_mode) ? PH_SKIP : PH_ADDR;
								d.lanes = 4'd2;
								d.dmy   = DREAD_DUMMY;
								d.cnt   = 6'h00;
							end
							default: begin
							end
						endcase
						if (d.phase == PH_SKIP && (op != OP_WREN && op != OP_WRDI &&
						                           op != OP_VWREN)) begin
							d.cmd = OP_NONE;
						end
					end
				end
				PH_ADDR: begin
					d.sh  = sh_next;
					d.cnt = cnt_next;
					if (cnt_next == ADDR_BITS) begin
						d.addr  = sh_next;
						d.cnt   = 6'h00;
						d.phase = (q.dmy == 4'h0) ? PH_OUT : PH_DUMMY;
					end
				end
				PH_DUMMY: begin
					// Lines stay released; output is don't-care here
					d.cnt = q.cnt + 6'd1;
					if (q.cnt + 6'd1 == {2'b00, q.dmy}) begin
						d.phase = PH_OUT;
					end
				end
				PH_IN: begin
					d.sh  = sh_next;
					d.cnt = cnt_next;
				end
				PH_OUT, PH_SKIP: begin
					d.cnt = cnt_next;
				end
				default: begin
				end
			endcase
		end else if (sclk_fall && q.phase == PH_OUT) begin
			// Fetch a fresh byte when the previous one is used up
			if (q.obits == 4'h0) begin
				cur_byte = src_byte;
				cur_bits = 4'd8;
			end else begin
				cur_byte = q.ob;
				cur_bits = q.obits;
			end
			unique case (q.lanes)
				4'd2: begin
					d.io_out = {2'b00, cur_byte[7:6]};
					d.io_oe  = 4'b0011;
				end
				4'd4: begin
					d.io_out = cur_byte[7:4];
					d.io_oe  = 4'b1111;
				end
				default: begin
					d.io_out = {2'b00, cur_byte[7], 1'b0};
					d.io_oe  = 4'b0010;
				end
			endcase
			d.ob    = 8'(cur_byte << q.lanes);
			d.obits = cur_bits - q.lanes;
			// Array pointer moves once per whole byte; status bytes repeat
			if (d.obits == 4'h0 && q.src == SRC_ARRAY) begin
				d.addr = q.addr + 24'd1;
			end
		end

		// Reads always pull from the array except the two status reads
		if (sclk_rise && q.phase == PH_OPCODE && cnt_next == OPCODE_BITS &&
		    op != OP_RDSR1 && op != OP_RDSR2) begin
			d.src = SRC_ARRAY;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			q <= CORE_RESET;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign o_io                 = q.io_out;
	assign o_io_oe              = q.io_oe;
	assign o_status1            = {q.sr1_hi, q.write_enable_latch, q.busy};
	assign o_status2            = q.sr2;
	assign o_busy               = q.busy;
	assign o_write_enable_latch = q.write_enable_latch;
	assign o_volatile_enable    = q.vol_en;
	assign o_dummy6             = q.dummy6;

endmodule

//--- sfc_core_monitor.sv
// Purpose: Concurrent checks on the flash command block's ports
// Assumes: Single i_clock domain, synchronous active-high reset
// Notes:   Bound to every sfc_core instance
`timescale 1ns/10ps
module sfc_core_monitor
	import sfc_pkg::*;
#(
	parameter int TW_CYC = TW_CYCLES
)
(
	input wire logic       i_clock,
	input wire logic       i_srst,
	input wire logic       i_cs_n,
	input wire logic       i_quad_cmd_mode,
	input wire logic [3:0] o_io_oe,
	input wire logic [7:0] o_status1,
	input wire logic [7:0] o_status2,
	input wire logic       o_busy,
	input wire logic       o_write_enable_latch
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);

	// ------------------------------------------------------------------
	// Busy length counter
	// ------------------------------------------------------------------
	logic [31:0] busy_cnt_q;
	always_ff @(posedge i_clock)
		busy_cnt_q <= (i_srst || !o_busy) ? 32'h0 : busy_cnt_q + 32'h1;

	sequence s_streaming;
		(!i_cs_n && o_io_oe != 4'h0) [*3] ##1 !i_cs_n;
	endsequence

	a_wel_cause: assert property ($rose(o_write_enable_latch) |-> i_cs_n && $past(i_cs_n))
		else $error("latch set inside a frame");
	a_busy_cause: assert property ($rose(o_busy) |-> i_cs_n && $past(i_cs_n))
		else $error("busy started inside a frame");
	a_latch_drop: assert property ($rose(o_busy) |-> ##[0:1] !o_write_enable_latch)
		else $error("latch not cleared when busy rose");
	a_wel_in_busy: assert property (o_busy && $past(o_busy) |-> !o_write_enable_latch)
		else $error("latch set during write cycle");
	a_busy_len: assert property ($fell(o_busy) |->
		busy_cnt_q >= TW_CYC - 1 && busy_cnt_q <= TW_CYC + 1)
		else $error("write cycle length wrong");
	a_status_mirror: assert property (o_status1[1:0] == {o_write_enable_latch, o_busy})
		else $error("status register 1 low bits disagree");
	a_reserved_zero: assert property ((o_status2 & ~SR2_WMASK) == 8'h00)
		else $error("read-only status 2 bit changed");
	a_idle_quiet: assert property (i_cs_n [*6] |-> o_io_oe == 4'h0)
		else $error("lines driven while deselected");
	a_lane_groups: assert property (o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("illegal line enable pattern");
	a_quad_only: assert property (!i_quad_cmd_mode [*8] |-> o_io_oe[3:2] == 2'b00)
		else $error("upper lines driven outside quad mode");
	a_oe_hold: assert property (s_streaming |-> o_io_oe != 4'h0)
		else $error("output stream stopped before deselect");
endmodule

bind sfc_core sfc_core_monitor #(.TW_CYC(TW_CYC)) u_monitor (
	.i_clock(i_clock), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_quad_cmd_mode(i_quad_cmd_mode),
	.o_io_oe(o_io_oe), .o_status1(o_status1), .o_status2(o_status2), .o_busy(o_busy),
	.o_write_enable_latch(o_write_enable_latch));

//--- sfc_host_model.sv
// Purpose: Behavioural host controller driving the flash link pins
// Assumes: Link clock period 400 ns, mode 0, clock still between frames
// Notes:   Released lines show the inverse of the last driven value
`timescale 1ns/10ps
module sfc_host_model
	import sfc_pkg::*;
(
	// Host-driven pins
	output logic            o_cs_n,
	output logic            o_sclk,
	output logic [3:0]      o_io,
	output logic [3:0]      o_io_oe,
	// Resolved lines
	input  wire logic [3:0] i_io
);
	localparam int HALF_NS = 200;

	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_io = 4'h0;
		o_io_oe = 4'h0;
	end

	// ------------------------------------------------------------------
	// One framed command: write clocks, then read clocks, lines released
	// ------------------------------------------------------------------
	// Sampling late in the high phase tolerates the device's sync latency
	task automatic frame(input logic [31:0] wr, input int nwr, input int lanes,
		input int nrd, input int rlanes, output logic [31:0] rd);
		logic [3:0] msk;
		msk = 4'((32'h1 << lanes) - 32'h1);
		rd = '0;
		o_cs_n = 1'b0;
		for (int k = nwr - 1; k >= 0; k--) begin
			o_io = 4'(wr >> (k * lanes)) & msk;
			o_io_oe = msk;
			#(HALF_NS) o_sclk = 1'b1;
			#(HALF_NS) o_sclk = 1'b0;
		end
		o_io = ~o_io; // No pull on the lines, so never leave the old value
		o_io_oe = 4'h0;
		for (int k = 0; k < nrd; k++) begin
			#(HALF_NS) o_sclk = 1'b1;
			#(HALF_NS - 10);
			if (rlanes == 1)
				rd = {rd[30:0], i_io[1]};
			else if (rlanes == 2)
				rd = {rd[29:0], i_io[1:0]};
			else
				rd = {rd[27:0], i_io};
			#10 o_sclk = 1'b0;
		end
		#(HALF_NS) o_cs_n = 1'b1;
		#(2 * HALF_NS);
	endtask
endmodule

//--- sfc_pin_sync.sv
// Purpose: Two-stage synchroniser for the link pins with edge pulses
// Assumes: Link clock far slower than i_clock (several cycles per phase)
// Notes:   Edges are taken between stages two and three only
`timescale 1ns/10ps
module sfc_pin_sync
	import sfc_pkg::*;
(
	// Clock and reset
	input  wire logic      i_clock,
	input  wire logic      i_srst,
	// Raw pins
	input  wire sfc_pins_t i_pins,
	// Synchronised view
	output sfc_pins_t      o_pins,
	output logic           o_sclk_rise,
	output logic           o_sclk_fall,
	output logic           o_cs_rise
);

	sfc_sync_t q;
	sfc_sync_t d;

	// ------------------------------------------------------------------
	// Pipeline
	// ------------------------------------------------------------------
	// First stage feeds only the second; metastability stays contained
	always_comb begin
		d    = q;
		d.s1 = i_pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			q <= SYNC_RESET;
		end else begin
			q <= d;
		end
	end

	// Edge pulses, one i_clock cycle wide
	assign o_pins      = q.s2;
	assign o_sclk_rise = q.s2.sclk & ~q.s3.sclk;
	assign o_sclk_fall = ~q.s2.sclk & q.s3.sclk;
	assign o_cs_rise   = q.s2.cs_n & ~q.s3.cs_n;

endmodule

//--- sfc_pkg.sv
// Purpose: Shared constants and types for the serial flash command block
// Assumes: 20 MHz system clock, link pins sampled through two flip-flops
// Notes:   Opcodes, status layout, dummy counts and write-cycle timing
package sfc_pkg;

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [7:0] OP_WREN     = 8'h06;
	localparam logic [7:0] OP_WRDI     = 8'h04;
	localparam logic [7:0] OP_VWREN    = 8'h50;
	localparam logic [7:0] OP_RDSR1    = 8'h05;
	localparam logic [7:0] OP_RDSR2    = 8'h35;
	localparam logic [7:0] OP_WRSR     = 8'h01;
	localparam logic [7:0] OP_WRSR2    = 8'h31;
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_FREAD    = 8'h0b;
	localparam logic [7:0] OP_DREAD    = 8'h3b;
	localparam logic [7:0] OP_SETPARAM = 8'hc0;
	localparam logic [7:0] OP_NONE     = 8'h00;

	// ------------------------------------------------------------------
	// Status layout and reset values
	// ------------------------------------------------------------------
	// Reg1: 7 protect0, 6 sector, 5 top/bottom, 4..2 block protect, 1 latch, 0 busy
	// Reg2: 6 complement, 1 quad enable, 0 protect1
	localparam logic [7:0] SR1_WMASK = 8'hfc;
	localparam logic [7:0] SR2_WMASK = 8'h43;
	localparam logic [7:0] SR1_RESET = 8'h00;
	localparam logic [7:0] SR2_RESET = 8'h00;
	localparam int         PARAM_DUMMY_BIT = 4;

	// ------------------------------------------------------------------
	// Frame geometry
	// ------------------------------------------------------------------
	localparam logic [5:0] OPCODE_BITS     = 6'd8;
	localparam logic [5:0] ADDR_BITS       = 6'd24;
	localparam logic [5:0] WR_ONE_BYTE     = 6'd8;
	localparam logic [5:0] WR_TWO_BYTES    = 6'd16;
	localparam logic [5:0] CNT_SAT         = 6'd59;
	localparam logic [3:0] SPI_FREAD_DUMMY = 4'd8;
	localparam logic [3:0] DREAD_DUMMY     = 4'd8;
	localparam logic [3:0] QPI_DUMMY_SHORT = 4'd4;
	localparam logic [3:0] QPI_DUMMY_LONG  = 4'd6;
	localparam int         ARRAY_AW        = 22;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int TW_TIME_NS    = 5000000;
	localparam int TW_CYCLES     = (TW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_OUT, PH_IN, PH_SKIP} sfc_phase_t;
	typedef enum logic [1:0] {SRC_SR1, SRC_SR2, SRC_ARRAY} sfc_src_t;

	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] io;
	} sfc_pins_t;

	typedef struct packed {
		sfc_pins_t s1;
		sfc_pins_t s2;
		sfc_pins_t s3;
	} sfc_sync_t;

	typedef struct packed {
		sfc_phase_t  phase;
		sfc_src_t    src;
		logic [7:0]  cmd;
		logic [23:0] sh;
		logic [5:0]  cnt;
		logic [3:0]  dmy;
		logic [3:0]  lanes;
		logic [7:0]  ob;
		logic [3:0]  obits;
		logic [23:0] addr;
		logic [5:0]  sr1_hi;
		logic [7:0]  sr2;
		logic        write_enable_latch;
		logic        vol_en;
		logic        busy;
		logic        dummy6;
		logic [31:0] tw_cnt;
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
	} sfc_core_t;

	localparam sfc_pins_t PINS_IDLE  = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
	localparam sfc_sync_t SYNC_RESET = '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE};
	localparam sfc_core_t CORE_RESET = '{
		phase: PH_OPCODE, src: SRC_SR1, cmd: 8'h00, sh: 24'h000000, cnt: 6'h00,
		dmy: 4'h0, lanes: 4'h1, ob: 8'h00, obits: 4'h0, addr: 24'h000000,
		sr1_hi: SR1_RESET[7:2], sr2: SR2_RESET, write_enable_latch: 1'b0, vol_en: 1'b0,
		busy: 1'b0, dummy6: 1'b0, tw_cnt: 32'h00000000, io_out: 4'h0, io_oe: 4'h0};

endpackage

//--- spi_flash_status_and_read_cmds_tb.sv
// Purpose: Self-checking bench for the flash command block
// Assumes: Host model drives the link; short write cycle for run time
// Notes:   Inputs change 1 ns after the rising clock edge
`timescale 1ns/10ps
module spi_flash_status_and_read_cmds_tb;
	import sfc_pkg::*;
	localparam int TW = 1000;
	logic        i_clock, i_srst, quad, ld_en, busy, write_enable_latch, vol, dmy6, oe_seen;
	logic [21:0] ld_addr;
	logic [7:0]  ld_data, st1, st2;
	logic        cs_n, sclk;
	logic [3:0]  h_io, h_oe, d_io, d_oe, line;
	logic [31:0] rd;
	int          n_fail, check_count;

	// ------------------------------------------------------------------
	// Wiring: device wins where it drives, else the host's value
	// ------------------------------------------------------------------
	assign line = (d_oe & d_io) | (~d_oe & h_io);
	sfc_core #(.TW_CYC(TW)) u_dut (.i_clock(i_clock), .i_srst(i_srst), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_io(line), .o_io(d_io), .o_io_oe(d_oe), .i_quad_cmd_mode(quad),
		.i_ld_en(ld_en), .i_ld_addr(ld_addr), .i_ld_data(ld_data), .o_status1(st1),
		.o_status2(st2), .o_busy(busy), .o_write_enable_latch(write_enable_latch),
		.o_volatile_enable(vol), .o_dummy6(dmy6));
	sfc_host_model u_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_io(h_io), .o_io_oe(h_oe),
		.i_io(line));

	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	// Remembers any device drive during a refused read; falling edge keeps clear of updates
	always @(negedge i_clock) begin
		if (d_oe != 4'h0)
			oe_seen <= 1'b1;
		if ((d_oe & h_oe) != 4'h0)
			check("line contention", d_oe & h_oe, 4'h0);
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		u_host.frame({24'h0, op}, 8, 1, 0, 1, rd);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2 * TW) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		check("busy end", busy, 0);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_latch();
		cmd(OP_WREN);
		check("latch on", write_enable_latch, 1);
		u_host.frame({24'h0, OP_RDSR1}, 8, 1, 16, 1, rd);
		check("status stream", rd[15:0], 16'h0202);
		cmd(OP_VWREN);
		check("latch kept", write_enable_latch, 1);
		check("volatile on", vol, 1);
		cmd(OP_WRDI);
		check("latch off", write_enable_latch, 0);
		u_host.frame({16'h0, OP_WRSR, 8'h1c}, 16, 1, 0, 1, rd);
		check("volatile write", st1, 8'h1c);
		check("no busy", busy, 0);
		check("short clears reg2", st2, 8'h00);
		$display("test latch done");
	endtask
	task automatic t_write();
		cmd(OP_WREN);
		u_host.frame({8'h0, OP_WRSR, 16'hffff}, 24, 1, 0, 1, rd);
		check("busy on", busy, 1);
		check("latch cleared", write_enable_latch, 0);
		check("reg1 mask", st1, 8'hfd);
		check("reg2 mask", st2, 8'h43);
		oe_seen = 1'b0;
		u_host.frame({OP_READ, 24'h10}, 32, 1, 8, 1, rd);
		check("read while busy", oe_seen, 0);
		u_host.frame({24'h0, OP_RDSR1}, 8, 1, 8, 1, rd);
		check("poll status", rd[7:0], 8'hfd);
		wait_idle();
		check("latch after", write_enable_latch, 0);
		check("reg1 after", st1, 8'hfc);
		$display("test write done");
	endtask
	task automatic t_short();
		cmd(OP_WREN);
		u_host.frame({16'h0, OP_WRSR, 8'h00}, 16, 1, 0, 1, rd);
		wait_idle();
		check("reg2 cleared", st2, 8'h00);
		u_host.frame({16'h0, OP_WRSR2, 8'h43}, 16, 1, 0, 1, rd);
		check("no latch refused", st2, 8'h00);
		cmd(OP_WREN);
		u_host.frame({12'h0, OP_WRSR, 12'hfff}, 20, 1, 0, 1, rd);
		check("odd length refused", st1, 8'h02);
		u_host.frame({16'h0, OP_WRSR2, 8'h43}, 16, 1, 0, 1, rd);
		check("reg2 busy", busy, 1);
		wait_idle();
		check("reg2 written", st2, 8'h43);
		check("reg1 untouched", st1, 8'h00);
		u_host.frame({24'h0, OP_RDSR2}, 8, 1, 8, 1, rd);
		check("status 2 read", rd[7:0], 8'h43);
		$display("test short done");
	endtask
	task automatic t_reads();
		logic [7:0] img [4] = '{8'ha5, 8'h3c, 8'h96, 8'he1};
		for (int i = 0; i < 4; i++) begin
			ld_en = 1'b1;
			ld_addr = 22'h10 + 22'(i);
			ld_data = img[i];
			@(posedge i_clock);
			#1;
		end
		ld_en = 1'b0;
		u_host.frame({OP_READ, 24'h10}, 32, 1, 16, 1, rd);
		check("read stream", rd[15:0], 16'ha53c);
		u_host.frame({OP_FREAD, 24'h11}, 32, 1, 16, 1, rd);
		check("fast read", rd[7:0], 8'h3c);
		u_host.frame({OP_DREAD, 24'h12}, 32, 1, 12, 2, rd);
		check("dual read", rd[7:0], 8'h96);
		@(posedge i_clock);
		#1 quad = 1'b1;
		u_host.frame({OP_FREAD, 24'h13}, 8, 4, 6, 4, rd);
		check("quad four dummies", rd[7:0], 8'he1);
		u_host.frame({16'h0, OP_SETPARAM, 8'h10}, 4, 4, 0, 4, rd);
		check("six dummies set", dmy6, 1);
		u_host.frame({OP_FREAD, 24'h13}, 8, 4, 8, 4, rd);
		check("quad six dummies", rd[7:0], 8'he1);
		@(posedge i_clock);
		#1 quad = 1'b0;
		// Mid-run reset must bring the short dummy count back
		i_srst = 1'b1;
		repeat (2) @(posedge i_clock);
		#1 i_srst = 1'b0;
		repeat (4) @(posedge i_clock);
		#1 check("reset dummy again", dmy6, 0);
		$display("test reads done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#2000000;
		n_fail++;
		finish_test();
	end
	initial begin
		{i_srst, quad, ld_en, oe_seen} = 4'b1000;
		ld_addr = 22'h0;
		ld_data = 8'h00;
		n_fail = 0;
		check_count = 0;
		repeat (6) @(posedge i_clock);
		#1 i_srst = 1'b0;
		repeat (6) @(posedge i_clock);
		#1 check("reset dummy", dmy6, 0);
		check("reset latch", write_enable_latch, 0);
		t_latch();
		t_write();
		t_short();
		t_reads();
		finish_test();
	end
endmodule
